// [pkg/pdma_pkg.sv]
package pdma_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam int REG_AW = 12;
   localparam logic [11:0] OFF_RX_CUR_PTR = 12'h100;
   localparam logic [11:0] OFF_RX_CUR_CNT = 12'h104;
   localparam logic [11:0] OFF_TX_CUR_PTR = 12'h108;
   localparam logic [11:0] OFF_TX_CUR_CNT = 12'h10C;
   localparam logic [11:0] OFF_RX_NXT_PTR = 12'h110;
   localparam logic [11:0] OFF_RX_NXT_CNT = 12'h114;
   localparam logic [11:0] OFF_TX_NXT_PTR = 12'h118;
   localparam logic [11:0] OFF_TX_NXT_CNT = 12'h11C;
   localparam logic [11:0] OFF_CTRL = 12'h120;
   localparam logic [11:0] OFF_STAT = 12'h124;

   // ==========================================
   // control and status bit positions
   localparam int BIT_RX_CHAN_ON = 0;
   localparam int BIT_RX_CHAN_OFF = 1;
   localparam int BIT_TX_CHAN_ON = 8;
   localparam int BIT_TX_CHAN_OFF = 9;
   localparam int BIT_STAT_RX = 0;
   localparam int BIT_STAT_TX = 8;

   // ==========================================
   // item sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // ==========================================
   // state of the channel pair
   typedef struct packed {
      logic [1:0][31:0] addr;
      logic [1:0][15:0] len;
      logic [1:0][31:0] naddr;
      logic [1:0][15:0] nlen;
      logic [1:0] on;
      logic [1:0] bdone;
      logic [1:0] ball;
      logic busy;
      logic go;
      logic dir;
      logic [1:0] size;
      logic [31:0] rdat;
      logic [31:0] txd;
      logic txw;
      logic rxr;
   } pdma_state_t;
   localparam pdma_state_t PDMA_STATE_RST = '0;

   // ==========================================
   // memory access engine
   typedef enum logic {
      PDMA_IDLE = 1'b0,
      PDMA_REQ = 1'b1
   } pdma_eng_st_t;

   typedef struct packed {
      pdma_eng_st_t st;
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] size;
      logic done;
      logic [31:0] rdata;
   } pdma_eng_t;
   localparam pdma_eng_t PDMA_ENG_RST = '0;
endpackage

// [pkg/pdma_eng_if.sv]
`timescale 1ns/100ps
// ==========================================
// one-item request from the channel logic to the memory engine
interface pdma_eng_if;
   logic go;
   logic dir;
   logic [31:0] addr;
   logic [1:0] size;
   logic [31:0] wdata;
   logic done;
   logic [31:0] rdata;
   modport ctl (output go, output dir, output addr, output size, output wdata,
      input done, input rdata);
   modport eng (input go, input dir, input addr, input size, input wdata,
      output done, output rdata);
endinterface // pdma_eng_if

// [design/pdma_xfer.sv]
`timescale 1ns/100ps
// ==========================================
// memory engine: one access per go pulse, done pulse on acknowledge
module pdma_xfer (
   input wire logic core_clk,
   input wire logic rst,
   pdma_eng_if.eng ctl,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_size,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   pdma_pkg::pdma_eng_t s_r;
   pdma_pkg::pdma_eng_t s_nxt;

   // next state: receive items are memory writes, transmit items reads
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      case (s_r.st)
         pdma_pkg::PDMA_IDLE: begin
            if (ctl.go) begin
               s_nxt.st = pdma_pkg::PDMA_REQ;
               s_nxt.req = 1'b1;
               s_nxt.we = ~ctl.dir;
               s_nxt.addr = ctl.addr;
               s_nxt.wdata = ctl.wdata;
               s_nxt.size = ctl.size;
            end
         end
         pdma_pkg::PDMA_REQ: begin
            if (mem_ack) begin
               s_nxt.st = pdma_pkg::PDMA_IDLE;
               s_nxt.req = 1'b0;
               s_nxt.we = 1'b0;
               s_nxt.done = 1'b1;
               s_nxt.rdata = mem_rdata;
            end
         end
         default: begin
            s_nxt = pdma_pkg::PDMA_ENG_RST;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= pdma_pkg::PDMA_ENG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign mem_req = s_r.req;
   assign mem_we = s_r.we;
   assign mem_addr = s_r.addr;
   assign mem_wdata = s_r.wdata;
   assign mem_size = s_r.size;
   assign ctl.done = s_r.done;
   assign ctl.rdata = s_r.rdata;
endmodule // pdma_xfer

// [design/pdma_regs.sv]
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Function
// - half duplex shares current pointer register
// - half duplex shares current count register
// - receive count zero halts, nonzero proceeds
// - transmit count zero halts, nonzero proceeds
// - next receive pointer and count registers
// - next transmit pointer and count registers
// - half duplex shares next pointer and count
// - receive enable bit unless disable also set
// - half duplex receive enable drops transmit
// - receive disable; half duplex disables both
// - transmit enable; half duplex yields to receive
// - transmit disable; half duplex disables both
// - status bit 0 shows receive enabled
// - status bit 8 shows transmit enabled
// - pointer advances by item size
// - current count reaching zero reloads from next when next count is nonzero
// - end and all-buffers flags to peripheral
module pdma_regs #(
   parameter bit HALF_DUPLEX = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [1:0] xfer_size,
   input wire logic rx_ready,
   input wire logic [31:0] peripheral_rx_holding,
   output logic rx_hold_rd,
   input wire logic tx_ready,
   output logic [31:0] peripheral_tx_holding,
   output logic tx_hold_wr,
   output logic rx_buffer_done,
   output logic tx_buffer_done,
   output logic rx_all_buffers_full,
   output logic tx_all_buffers_empty,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [1:0] mem_size,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   // ==========================================
   // helpers

   // register slot of a direction; half duplex folds both onto slot 0
   function automatic logic slot(input logic dir);
      slot = HALF_DUPLEX ? 1'b0 : dir;
   endfunction

   // byte step of one item
   function automatic logic [31:0] step(input logic [1:0] sz);
      case (sz)
         pdma_pkg::SIZE_BYTE: step = 32'h0000_0001;
         pdma_pkg::SIZE_HALF: step = 32'h0000_0002;
         pdma_pkg::SIZE_WORD: step = 32'h0000_0004;
         default: step = 32'h0000_0004;
      endcase
   endfunction

   // ==========================================
   // state and engine link

   pdma_pkg::pdma_state_t s_r;
   pdma_pkg::pdma_state_t s_nxt;
   pdma_eng_if eng ();
   logic txs;
   logic rx_want;
   logic tx_want;
   logic c;
   logic [15:0] newlen;
   logic [31:0] d;

   assign txs = slot(1'b1);
   assign d = reg_wdata;

   // requests from the peripheral, gated by enable and count
   assign rx_want = rx_ready && s_r.on[0] && (s_r.len[0] != 16'h0000);
   assign tx_want = tx_ready && s_r.on[1] && (s_r.len[txs] != 16'h0000);

   // ==========================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.go = 1'b0;
      s_nxt.txw = 1'b0;
      s_nxt.rxr = 1'b0;
      s_nxt.rdat = 32'h0000_0000;
      c = slot(s_r.dir);
      newlen = s_r.len[c] - 16'h0001;

      // start one item when the engine is free; receive first
      if (!s_r.busy && !s_r.go) begin
         if (rx_want) begin
            s_nxt.go = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.dir = 1'b0;
            s_nxt.size = xfer_size;
            s_nxt.rxr = 1'b1;
         end else if (tx_want) begin
            s_nxt.go = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.dir = 1'b1;
            s_nxt.size = xfer_size;
         end
      end

      // item finished: step pointer, count down, reload or flag
      if (eng.done) begin
         s_nxt.busy = 1'b0;
         if (s_r.dir) begin
            s_nxt.txd = eng.rdata;
            s_nxt.txw = 1'b1;
         end
         if (s_r.len[c] != 16'h0000) begin
            s_nxt.addr[c] = s_r.addr[c] + step(s_r.size);
            s_nxt.len[c] = newlen;
            if (newlen == 16'h0000) begin
               if (s_r.nlen[c] != 16'h0000) begin
                  s_nxt.addr[c] = s_r.naddr[c];
                  s_nxt.len[c] = s_r.nlen[c];
                  s_nxt.naddr[c] = 32'h0000_0000;
                  s_nxt.nlen[c] = 16'h0000;
               end
            end
         end
      end

      // software writes; a new pointer takes effect mid buffer
      if (reg_wr) begin
         case (reg_addr)
            pdma_pkg::OFF_RX_CUR_PTR: s_nxt.addr[0] = d;
            pdma_pkg::OFF_TX_CUR_PTR: s_nxt.addr[txs] = d;
            pdma_pkg::OFF_RX_CUR_CNT: s_nxt.len[0] = d[15:0];
            pdma_pkg::OFF_TX_CUR_CNT: s_nxt.len[txs] = d[15:0];
            pdma_pkg::OFF_RX_NXT_PTR: s_nxt.naddr[0] = d;
            pdma_pkg::OFF_TX_NXT_PTR: s_nxt.naddr[txs] = d;
            pdma_pkg::OFF_RX_NXT_CNT: s_nxt.nlen[0] = d[15:0];
            pdma_pkg::OFF_TX_NXT_CNT: s_nxt.nlen[txs] = d[15:0];
            pdma_pkg::OFF_CTRL: begin
               // enables first, disables after, so a disable always wins
               if (d[pdma_pkg::BIT_RX_CHAN_ON] && !d[pdma_pkg::BIT_RX_CHAN_OFF]) begin
                  s_nxt.on[0] = 1'b1;
                  if (HALF_DUPLEX) begin
                     s_nxt.on[1] = 1'b0;
                  end
               end
               if (d[pdma_pkg::BIT_TX_CHAN_ON]
                     && !(HALF_DUPLEX && d[pdma_pkg::BIT_RX_CHAN_ON])) begin
                  s_nxt.on[1] = 1'b1;
                  if (HALF_DUPLEX) begin
                     s_nxt.on[0] = 1'b0;
                  end
               end
               if (d[pdma_pkg::BIT_RX_CHAN_OFF]) begin
                  s_nxt.on[0] = 1'b0;
                  if (HALF_DUPLEX) begin
                     s_nxt.on[1] = 1'b0;
                  end
               end
               if (d[pdma_pkg::BIT_TX_CHAN_OFF]) begin
                  s_nxt.on[1] = 1'b0;
                  if (HALF_DUPLEX) begin
                     s_nxt.on[0] = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // flags: cleared by a nonzero count write, set wins over clear
      if (reg_wr && (d[15:0] != 16'h0000)) begin
         if (reg_addr == pdma_pkg::OFF_RX_CUR_CNT || reg_addr == pdma_pkg::OFF_RX_NXT_CNT) begin
            s_nxt.bdone[0] = 1'b0;
            s_nxt.ball[0] = 1'b0;
         end
         if (reg_addr == pdma_pkg::OFF_TX_CUR_CNT || reg_addr == pdma_pkg::OFF_TX_NXT_CNT) begin
            s_nxt.bdone[txs] = 1'b0;
            s_nxt.ball[txs] = 1'b0;
         end
      end
      if (eng.done && s_r.len[c] == 16'h0001) begin
         s_nxt.bdone[c] = 1'b1;
         if (s_r.nlen[c] == 16'h0000) begin
            s_nxt.ball[c] = 1'b1;
         end
      end

      // register read, data in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            pdma_pkg::OFF_RX_CUR_PTR: s_nxt.rdat = s_r.addr[0];
            pdma_pkg::OFF_TX_CUR_PTR: s_nxt.rdat = s_r.addr[txs];
            pdma_pkg::OFF_RX_CUR_CNT: s_nxt.rdat = {16'h0000, s_r.len[0]};
            pdma_pkg::OFF_TX_CUR_CNT: s_nxt.rdat = {16'h0000, s_r.len[txs]};
            pdma_pkg::OFF_RX_NXT_PTR: s_nxt.rdat = s_r.naddr[0];
            pdma_pkg::OFF_TX_NXT_PTR: s_nxt.rdat = s_r.naddr[txs];
            pdma_pkg::OFF_RX_NXT_CNT: s_nxt.rdat = {16'h0000, s_r.nlen[0]};
            pdma_pkg::OFF_TX_NXT_CNT: s_nxt.rdat = {16'h0000, s_r.nlen[txs]};
            pdma_pkg::OFF_STAT: begin
               s_nxt.rdat[pdma_pkg::BIT_STAT_RX] = s_r.on[0];
               s_nxt.rdat[pdma_pkg::BIT_STAT_TX] = s_r.on[1];
            end
            default: s_nxt.rdat = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_r <= pdma_pkg::PDMA_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // engine request and outputs
   assign eng.go = s_r.go;
   assign eng.dir = s_r.dir;
   assign eng.addr = s_r.addr[slot(s_r.dir)];
   assign eng.size = s_r.size;
   assign eng.wdata = peripheral_rx_holding;

   pdma_xfer u_xfer (
      .core_clk(core_clk),
      .rst(rst),
      .ctl(eng.eng),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_size(mem_size),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );

   // register-driven outputs
   assign reg_rdata = s_r.rdat;
   assign rx_hold_rd = s_r.rxr;
   assign peripheral_tx_holding = s_r.txd;
   assign tx_hold_wr = s_r.txw;
   assign rx_buffer_done = s_r.bdone[0];
   assign tx_buffer_done = s_r.bdone[txs];
   assign rx_all_buffers_full = s_r.ball[0];
   assign tx_all_buffers_empty = s_r.ball[txs];

   // ==========================================
   // checks
   AST_RX_ON: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == pdma_pkg::OFF_CTRL && d[0] && !d[1] && !d[9] |=> s_r.on[0])
      else $error("receive enable write ignored");
   AST_RX_OFF: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == pdma_pkg::OFF_CTRL && d[1]
      |=> !s_r.on[0] && (!HALF_DUPLEX || !s_r.on[1]))
      else $error("receive disable write ignored");
   AST_TX_ON: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == pdma_pkg::OFF_CTRL && d[8] && !d[9] && !d[1]
      && !(HALF_DUPLEX && d[0]) |=> s_r.on[1])
      else $error("transmit enable write ignored");
   AST_TX_OFF: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr && reg_addr == pdma_pkg::OFF_CTRL && d[9]
      |=> !s_r.on[1] && (!HALF_DUPLEX || !s_r.on[0]))
      else $error("transmit disable write ignored");
   AST_HALF_EXCL: assert property (@(posedge core_clk) disable iff (rst)
      HALF_DUPLEX |-> !(s_r.on[0] && s_r.on[1]))
      else $error("both directions enabled in half duplex");
   AST_STATUS: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == pdma_pkg::OFF_STAT
      |=> reg_rdata[0] == $past(s_r.on[0]) && reg_rdata[8] == $past(s_r.on[1]))
      else $error("status read wrong");
   AST_ZERO_HALT: assert property (@(posedge core_clk) disable iff (rst)
      s_r.go && !s_r.dir |-> $past(s_r.len[0]) != 16'h0000 && $past(s_r.on[0]))
      else $error("receive started with zero count");
   AST_DEC: assert property (@(posedge core_clk) disable iff (rst)
      eng.done && !s_r.dir && !reg_wr && s_r.len[0] > 16'h0001
      |=> s_r.len[0] == $past(s_r.len[0]) - 16'h0001
      && s_r.addr[0] == $past(s_r.addr[0]) + step($past(s_r.size)))
      else $error("count or pointer not stepped");
   AST_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
      eng.done && !s_r.dir && !reg_wr && s_r.len[0] == 16'h0001 && s_r.nlen[0] != 16'h0000
      |=> s_r.len[0] == $past(s_r.nlen[0]) && s_r.addr[0] == $past(s_r.naddr[0])
      && s_r.nlen[0] == 16'h0000 && rx_buffer_done)
      else $error("next buffer not loaded");
   AST_FULL: assert property (@(posedge core_clk) disable iff (rst)
      eng.done && !s_r.dir && s_r.len[0] == 16'h0001 && s_r.nlen[0] == 16'h0000
      |=> rx_all_buffers_full && rx_buffer_done)
      else $error("all-buffers flag not raised");
endmodule // pdma_regs

// [tb/pdma_peer.sv]
`timescale 1ns/100ps
// ==========================================
// peer model: serial peripheral with holding registers, and memory
module pdma_peer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] lat,
   input wire logic [7:0] rx_goal,
   input wire logic [7:0] tx_goal,
   input wire logic rx_hold_rd,
   input wire logic tx_hold_wr,
   input wire logic [31:0] peripheral_tx_holding,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   output logic rx_ready,
   output logic tx_ready,
   output logic [31:0] peripheral_rx_holding,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [7:0] rx_n;
   logic [7:0] tx_n;
   logic [7:0] wr_n;
   logic [3:0] wait_r;
   logic [31:0] tx_seen;
   logic [31:0] waddr [0:15];

   // ready stays up while items are still owed in that direction
   assign rx_ready = rx_n != rx_goal;
   assign tx_ready = tx_n != tx_goal;
   assign peripheral_rx_holding = 32'hD000_0000 | {24'h0, rx_n};

   // memory acks after lat wait cycles; read data is junk outside the ack
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_n <= 8'h00;
         tx_n <= 8'h00;
         wr_n <= 8'h00;
         wait_r <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         tx_seen <= 32'h0;
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~{mem_addr[15:0], 16'hBEEF};
         if (mem_req && !mem_ack) begin
            if (wait_r == lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= {mem_addr[15:0], 16'hBEEF};
               wait_r <= 4'h0;
               if (mem_we) begin
                  waddr[wr_n[3:0]] <= mem_addr;
                  wr_n <= wr_n + 8'h01;
               end else begin
                  tx_n <= tx_n + 8'h01;
               end
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
         if (rx_hold_rd) begin
            rx_n <= rx_n + 8'h01;
         end
         if (tx_hold_wr) begin
            tx_seen <= peripheral_tx_holding;
         end
      end
   end
endmodule // pdma_peer

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   localparam logic [11:0] CTL [0:7] = '{12'h001, 12'h100, 12'h000, 12'h200,
      12'h003, 12'h101, 12'h002, 12'h300};
   localparam logic [11:0] STS [0:7] = '{12'h001, 12'h101, 12'h101, 12'h001,
      12'h000, 12'h101, 12'h100, 12'h000};
   logic core_clk;
   logic rst;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [1:0] xfer_size;
   logic [3:0] lat;
   logic [7:0] rx_goal;
   logic [7:0] tx_goal;
   logic rx_ready, rx_hold_rd, tx_ready, tx_hold_wr;
   logic [31:0] peripheral_rx_holding, peripheral_tx_holding;
   logic rx_buffer_done, tx_buffer_done, rx_all_buffers_full, tx_all_buffers_empty;
   logic mem_req, mem_we, mem_ack;
   logic [31:0] mem_addr, mem_rdata;
   logic [31:0] mem_wdata;
   logic [1:0] mem_size;
   logic [31:0] hd_rdata;
   int mismatches = 0;
   int total_checks = 0;

   pdma_regs #(.HALF_DUPLEX(1'b0)) uut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .xfer_size(xfer_size),
      .rx_ready(rx_ready),
      .peripheral_rx_holding(peripheral_rx_holding),
      .rx_hold_rd(rx_hold_rd),
      .tx_ready(tx_ready),
      .peripheral_tx_holding(peripheral_tx_holding),
      .tx_hold_wr(tx_hold_wr),
      .rx_buffer_done(rx_buffer_done),
      .tx_buffer_done(tx_buffer_done),
      .rx_all_buffers_full(rx_all_buffers_full),
      .tx_all_buffers_empty(tx_all_buffers_empty),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_size(mem_size),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );

   // half duplex copy on the same register bus, no traffic of its own
   pdma_regs #(.HALF_DUPLEX(1'b1)) uut_hd (
      .core_clk(core_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(hd_rdata),
      .xfer_size(2'h0),
      .rx_ready(1'b0),
      .peripheral_rx_holding(32'h0000_0000),
      .rx_hold_rd(),
      .tx_ready(1'b0),
      .peripheral_tx_holding(),
      .tx_hold_wr(),
      .rx_buffer_done(),
      .tx_buffer_done(),
      .rx_all_buffers_full(),
      .tx_all_buffers_empty(),
      .mem_req(),
      .mem_we(),
      .mem_addr(),
      .mem_wdata(),
      .mem_size(),
      .mem_ack(1'b0),
      .mem_rdata(32'h0000_0000)
   );

   pdma_peer peer (
      .core_clk(core_clk),
      .rst(rst),
      .lat(lat),
      .rx_goal(rx_goal),
      .tx_goal(tx_goal),
      .rx_hold_rd(rx_hold_rd),
      .tx_hold_wr(tx_hold_wr),
      .peripheral_tx_holding(peripheral_tx_holding),
      .mem_req(mem_req),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .rx_ready(rx_ready),
      .tx_ready(tx_ready),
      .peripheral_rx_holding(peripheral_rx_holding),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );

   // ==========================================
   // clock and shared tasks
   always #4 core_clk = ~core_clk;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), exp, reg_rdata);
   endtask

   // waits for the peer to count n items, bounded
   task automatic wait_n(input logic [7:0] n, input bit tx);
      for (int i = 0; i < 400; i++) begin
         @(posedge core_clk);
         if ((tx ? peer.tx_n : peer.wr_n) === n) break;
      end
      repeat (4) @(posedge core_clk);
   endtask

   // memory write data and item size against the peripheral sequence
   always @(posedge core_clk) begin
      if (!rst && mem_ack && mem_we) begin
         chk("mem_wdata", 32'hD000_0000 | {24'h0, peer.wr_n - 8'h01}, mem_wdata);
         chk("mem_size", {30'h0, xfer_size}, {30'h0, mem_size});
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // test sequence
   initial begin
      logic [31:0] v;
      core_clk = 1'b0;
      rst = 1'b1;
      reg_addr = 12'h000;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      xfer_size = 2'h0;
      lat = 4'h0;
      rx_goal = 8'h00;
      tx_goal = 8'h00;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) rd(12'h100 + 12'(4 * i), 32'h0);
      // distinct values per register, counts keep 16 bits
      for (int i = 0; i < 8; i++) wr(12'h100 + 12'(4 * i), 32'h8421_0000 | 32'(i * 4369));
      for (int i = 0; i < 8; i++) begin
         v = 32'h8421_0000 | 32'(i * 4369);
         rd(12'h100 + 12'(4 * i), (i % 2 == 1) ? {16'h0, v[15:0]} : v);
      end
      for (int i = 0; i < 8; i++) wr(12'h100 + 12'(4 * i), 32'h0);
      // control strobes against status
      for (int i = 0; i < 8; i++) begin
         wr(pdma_pkg::OFF_CTRL, {20'h0, CTL[i]});
         rd(pdma_pkg::OFF_STAT, {20'h0, STS[i]});
      end
      rd(pdma_pkg::OFF_CTRL, 32'h0);
      wr(pdma_pkg::OFF_STAT, 32'hFFFF_FFFF);
      rd(pdma_pkg::OFF_STAT, 32'h0);
      rd(12'h200, 32'h0);
      // zero count holds a pending receive item back
      wr(pdma_pkg::OFF_RX_CUR_PTR, 32'h0500);
      wr(pdma_pkg::OFF_CTRL, 32'h001);
      rx_goal <= 8'h01;
      repeat (20) @(posedge core_clk);
      chk("memory writes", 32'h0, {24'h0, peer.wr_n});
      // receive two buffers per item size, memory prompt then slow
      for (int s = 0; s < 3; s++) begin
         v = 32'h1000 << s;
         xfer_size <= 2'(s);
         lat <= 4'(3 * s);
         wr(pdma_pkg::OFF_RX_NXT_PTR, v + 32'h100);
         wr(pdma_pkg::OFF_RX_NXT_CNT, 32'h1);
         wr(pdma_pkg::OFF_RX_CUR_PTR, v);
         chk("rx_all_buffers_full", 32'h0, {31'h0, rx_all_buffers_full});
         wr(pdma_pkg::OFF_RX_CUR_CNT, 32'h2);
         rx_goal <= 8'(3 * s + 3);
         wait_n(8'(3 * s + 3), 1'b0);
         for (int i = 0; i < 3; i++) begin
            chk("write address", (i < 2) ? v + 32'(i << s) : v + 32'h100,
               peer.waddr[3 * s + i]);
         end
         rd(pdma_pkg::OFF_RX_CUR_PTR, v + 32'h100 + 32'(1 << s));
         rd(pdma_pkg::OFF_RX_CUR_CNT, 32'h0);
         rd(pdma_pkg::OFF_RX_NXT_PTR, 32'h0);
         rd(pdma_pkg::OFF_RX_NXT_CNT, 32'h0);
         chk("rx_buffer_done", 32'h1, {31'h0, rx_buffer_done});
         chk("rx_all_buffers_full", 32'h1, {31'h0, rx_all_buffers_full});
      end
      // transmit two words; count loaded while the channel is off
      lat <= 4'h2;
      xfer_size <= pdma_pkg::SIZE_WORD;
      tx_goal <= 8'h02;
      wr(pdma_pkg::OFF_TX_CUR_PTR, 32'h4000);
      wr(pdma_pkg::OFF_TX_CUR_CNT, 32'h2);
      repeat (10) @(posedge core_clk);
      chk("memory reads", 32'h0, {24'h0, peer.tx_n});
      wr(pdma_pkg::OFF_CTRL, 32'h100);
      wait_n(8'h02, 1'b1);
      chk("tx holding", 32'h4004_BEEF, peer.tx_seen);
      rd(pdma_pkg::OFF_TX_CUR_PTR, 32'h4008);
      rd(pdma_pkg::OFF_TX_CUR_CNT, 32'h0);
      chk("tx_buffer_done", 32'h1, {31'h0, tx_buffer_done});
      chk("tx_all_buffers_empty", 32'h1, {31'h0, tx_all_buffers_empty});
      // half duplex views share one register, enables exclude each other
      wr(pdma_pkg::OFF_RX_CUR_PTR, 32'h7000);
      rd(pdma_pkg::OFF_TX_CUR_PTR, 32'h4008);
      chk("hd tx pointer view", 32'h7000, hd_rdata);
      wr(pdma_pkg::OFF_TX_CUR_CNT, 32'h55);
      rd(pdma_pkg::OFF_RX_CUR_CNT, 32'h0);
      chk("hd rx count view", 32'h55, hd_rdata);
      wr(pdma_pkg::OFF_TX_NXT_PTR, 32'h7100);
      rd(pdma_pkg::OFF_RX_NXT_PTR, 32'h0);
      chk("hd rx next pointer view", 32'h7100, hd_rdata);
      wr(pdma_pkg::OFF_CTRL, 32'h001);
      rd(pdma_pkg::OFF_STAT, 32'h101);
      chk("hd status after rx enable", 32'h001, hd_rdata);
      wr(pdma_pkg::OFF_CTRL, 32'h200);
      rd(pdma_pkg::OFF_STAT, 32'h001);
      chk("hd status after tx disable", 32'h000, hd_rdata);
      tally_and_finish();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      tally_and_finish();
   end
endmodule // tb_top
